// ==== mlmc_pkg.sv ====
// Operation
// - packet mode starts receiving unless init bit set
// - enable command turns reception on
// - carrier-detect field: hold on or forward remote
// - DTR/DSR field: hold on or forward remote
// - RTS/CTS field: hold on or forward remote
// - hardware flow control overrides RTS/CTS field
// - periodic bit sends CR when no data is pending
// - collision avoidance waits for idle line
// - global-address replies only when reply bit set
// - delay bit selects short direct-mode delay
// - DCD becomes sync clock in direct mode
// - low-power mode only when enable bit set
// - control channel bit selects lowest frequency wait
// - aux clock field selects status clock rate
// - band field forces zero to default band
// - hardware flow uses RTS and CTS lines
package mlmc_pkg;

  // register indexes
  localparam logic [4:0] MLMC_IDX_LINE_MAP = 5'h16;
  localparam logic [4:0] MLMC_IDX_MULTIDROP = 5'h17;
  localparam logic [4:0] MLMC_IDX_SPECIAL = 5'h18;
  localparam logic [4:0] MLMC_IDX_LOW_POWER = 5'h19;
  localparam logic [4:0] MLMC_IDX_SPARE = 5'h1A;
  localparam logic [4:0] MLMC_IDX_BAND_AUX = 5'h1B;

  // reset values
  localparam logic [7:0] MLMC_RST_LINE_MAP = 8'h00;
  localparam logic [7:0] MLMC_RST_MULTIDROP = 8'h00;
  localparam logic [7:0] MLMC_RST_SPECIAL = 8'hC0;
  localparam logic [7:0] MLMC_RST_LOW_POWER = 8'h40;
  localparam logic [7:0] MLMC_RST_SPARE = 8'h00;
  localparam logic [7:0] MLMC_RST_BAND_AUX = 8'h01;

  // writable bit masks
  localparam logic [7:0] MLMC_MASK_LINE_MAP = 8'hBF;
  localparam logic [7:0] MLMC_MASK_MULTIDROP = 8'h17;
  localparam logic [7:0] MLMC_MASK_SPECIAL = 8'h30;
  localparam logic [7:0] MLMC_MASK_LOW_POWER = 8'hC0;
  localparam logic [7:0] MLMC_MASK_BAND_AUX = 8'h3F;

  // field positions
  localparam int MLMC_BIT_RX_INIT_OFF = 7;
  localparam int MLMC_POS_DCD = 4;
  localparam int MLMC_POS_DTR = 2;
  localparam int MLMC_POS_RTS = 0;
  localparam int MLMC_BIT_PERIODIC = 2;
  localparam int MLMC_BIT_COLL_AVOID = 1;
  localparam int MLMC_BIT_GLOBAL_REPLY = 0;
  localparam int MLMC_BIT_SHORT_DELAY = 5;
  localparam int MLMC_BIT_DCD_SYNC = 4;
  localparam int MLMC_BIT_LP_EN = 7;
  localparam int MLMC_BIT_CTRL_CHAN = 6;
  localparam int MLMC_POS_AUX_RATE = 4;
  localparam int MLMC_POS_BAND = 0;

  // field codes
  localparam logic [1:0] MLMC_LINE_HOLD_ON = 2'h0;
  localparam logic [1:0] MLMC_LINE_RSVD = 2'h1;
  localparam logic [3:0] MLMC_BAND_DEFAULT = 4'h1;
  localparam logic [3:0] MLMC_BAND_INVALID = 4'h2;
  localparam logic [3:0] MLMC_BAND_LAST = 4'h6;
  localparam logic [7:0] MLMC_CR_BYTE = 8'h0D;
  localparam logic [7:0] MLMC_GLOBAL_FIRST = 8'hF0;
  localparam logic [7:0] MLMC_GLOBAL_LAST = 8'hFE;

  // aux clock timing
  localparam int MLMC_SYS_CLK_KHZ = 200000;
  localparam int MLMC_AUX_SLOW_KHZ = 100;
  localparam int MLMC_AUX_MID_KHZ = 1140;
  localparam int MLMC_AUX_FAST_KHZ = 8000;
  localparam int MLMC_AUX_SLOW_CYC = MLMC_SYS_CLK_KHZ / MLMC_AUX_SLOW_KHZ;
  localparam int MLMC_AUX_MID_CYC = MLMC_SYS_CLK_KHZ / MLMC_AUX_MID_KHZ;
  localparam int MLMC_AUX_FAST_CYC = MLMC_SYS_CLK_KHZ / MLMC_AUX_FAST_KHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] idx;
    logic [7:0] wdata;
  } mlmc_regreq_type;

  typedef struct packed {
    logic done;
    logic is_tx;
    logic [7:0] addr;
  } mlmc_cmd_type;

  typedef struct packed {
    logic level;
    logic valid;
  } mlmc_remote_type;

endpackage

// ==== mlmc_line_fwd.sv ====
module mlmc_line_fwd
  import mlmc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // setting and remote line
  input wire logic [1:0] mode,
  input wire mlmc_remote_type remote,
  // local line
  output logic line_out
);

  logic [1:0] mode_eff;
  logic [1:0] mode_prev_reg;

  // reserved code acts as hold-on
  assign mode_eff = (mode == MLMC_LINE_RSVD) ? MLMC_LINE_HOLD_ON : mode;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mode_prev_reg <= MLMC_LINE_HOLD_ON;
    else if (ce)
      mode_prev_reg <= mode_eff;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      line_out <= 1'b1;
    else if (ce)
    begin
      if (!mode_eff[1])
        line_out <= 1'b1;
      else if (mode_eff != mode_prev_reg)
        line_out <= mode_eff[0];
      else if (remote.valid)
        line_out <= remote.level;
    end
  end

  a_hold_on_mode: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !mode_eff[1] |=> line_out)
    else $error("line not held on in hold mode");

endmodule

// ==== mlmc_aux_clk.sv ====
module mlmc_aux_clk
  import mlmc_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // rate select
  input wire logic [1:0] rate,
  // status clock
  output logic aux_clk
);

  // elaboration check: the slowest period must fit the counter
  if ((1 << CNT_W) <= MLMC_AUX_SLOW_CYC)
  begin : g_width_check
    $error("aux counter too narrow");
  end

  function automatic logic [CNT_W-1:0] period_of(input logic [1:0] r);
    unique case (r)
      2'h1: period_of = CNT_W'(MLMC_AUX_SLOW_CYC);
      2'h2: period_of = CNT_W'(MLMC_AUX_MID_CYC);
      2'h3: period_of = CNT_W'(MLMC_AUX_FAST_CYC);
      2'h0: period_of = '0;
    endcase
  endfunction

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] period;
  logic [1:0] rate_prev_reg;

  assign period = period_of(rate);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rate_prev_reg <= 2'h0;
    else if (ce)
      rate_prev_reg <= rate;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (ce)
    begin
      if (rate != rate_prev_reg || cnt_reg >= period - CNT_W'(1))
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      aux_clk <= 1'b0;
    else if (ce)
      aux_clk <= (rate != 2'h0) && (cnt_reg < (period >> 1));
  end

  a_aux_clk_off: assert property (@(posedge sys_clk) disable iff (rst)
    ce && rate == 2'h0 |=> !aux_clk)
    else $error("aux clock runs while disabled");

endmodule

// ==== mlmc_config.sv ====
module mlmc_config
  import mlmc_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // register access from the command interpreter
  input wire mlmc_regreq_type reg_req,
  output logic [7:0] reg_rdata_reg,
  output logic reg_ack_reg,
  // operating context
  input wire logic packet_mode,
  input wire logic direct_mode,
  input wire logic hw_flow,
  input wire logic rx_start,
  input wire logic cmd_rx_enable,
  input wire logic cmd_rx_disable,
  // remote control lines and local flow state
  input wire mlmc_remote_type remote_dcd,
  input wire mlmc_remote_type remote_dtr,
  input wire mlmc_remote_type remote_rts,
  input wire logic host_rx_ready,
  input wire logic direct_sync_clk,
  // multi-drop output timing
  input wire logic interval_expire,
  input wire logic line_busy,
  input wire logic out_pending,
  // command completion
  input wire mlmc_cmd_type cmd,
  // local control lines
  output logic dcd_out_reg,
  output logic dsr_out_reg,
  output logic cts_out_reg,
  // reception and output scheduling
  output logic rx_enabled_reg,
  output logic send_grant_reg,
  output logic send_cr_reg,
  output logic interval_restart_reg,
  output logic [7:0] cr_byte_reg,
  // replies
  output logic reply_accepted_reg,
  output logic reply_tx_accepted_reg,
  // direct and low-power modes
  output logic short_delay_reg,
  output logic lowpower_en_reg,
  output logic ctrl_channel_en_reg,
  // status clock and band
  output logic aux_clk_reg,
  output logic [3:0] band_sel_reg
);

  typedef enum logic [2:0] {
    MLMC_MD_READY = 3'b001,
    MLMC_MD_WAIT = 3'b010,
    MLMC_MD_RESTART = 3'b100
  } mlmc_md_state_type;

  logic [7:0] line_map_reg;
  logic [7:0] multidrop_reg;
  logic [7:0] special_reg;
  logic [7:0] low_power_reg;
  logic [7:0] band_aux_reg;
  mlmc_md_state_type md_state_reg;
  mlmc_md_state_type md_state_next;
  logic dcd_fwd;
  logic dsr_fwd;
  logic cts_fwd;
  logic aux_clk_int;
  logic periodic;
  logic coll_avoid;
  logic line_free;

  function automatic logic [1:0] line_code(input logic [1:0] c);
    line_code = (c == MLMC_LINE_RSVD) ? MLMC_LINE_HOLD_ON : c;
  endfunction

  function automatic logic [7:0] fix_line_map(input logic [7:0] d);
    logic [7:0] v;
    v = d & MLMC_MASK_LINE_MAP;
    v[MLMC_POS_DCD +: 2] = line_code(d[MLMC_POS_DCD +: 2]);
    v[MLMC_POS_DTR +: 2] = line_code(d[MLMC_POS_DTR +: 2]);
    v[MLMC_POS_RTS +: 2] = line_code(d[MLMC_POS_RTS +: 2]);
    fix_line_map = v;
  endfunction

  function automatic logic [3:0] fix_band(input logic [3:0] b);
    if (b == 4'h0 || b == MLMC_BAND_INVALID || b > MLMC_BAND_LAST)
      fix_band = MLMC_BAND_DEFAULT;
    else
      fix_band = b;
  endfunction

  function automatic logic is_global(input logic [7:0] a);
    is_global = (a >= MLMC_GLOBAL_FIRST) && (a <= MLMC_GLOBAL_LAST);
  endfunction

  function automatic logic wr_hit(input mlmc_regreq_type r, input logic [4:0] idx);
    wr_hit = r.wr && (r.idx == idx);
  endfunction

  // register writes, reserved bits and codes forced back to defaults
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      line_map_reg <= MLMC_RST_LINE_MAP;
      multidrop_reg <= MLMC_RST_MULTIDROP;
      special_reg <= MLMC_RST_SPECIAL;
      low_power_reg <= MLMC_RST_LOW_POWER;
      band_aux_reg <= MLMC_RST_BAND_AUX;
    end
    else if (ce)
    begin
      if (wr_hit(reg_req, MLMC_IDX_LINE_MAP))
        line_map_reg <= fix_line_map(reg_req.wdata);
      if (wr_hit(reg_req, MLMC_IDX_MULTIDROP))
        multidrop_reg <= reg_req.wdata & MLMC_MASK_MULTIDROP;
      if (wr_hit(reg_req, MLMC_IDX_SPECIAL))
        special_reg <= (reg_req.wdata & MLMC_MASK_SPECIAL)
          | (MLMC_RST_SPECIAL & ~MLMC_MASK_SPECIAL);
      if (wr_hit(reg_req, MLMC_IDX_LOW_POWER))
        low_power_reg <= reg_req.wdata & MLMC_MASK_LOW_POWER;
      if (wr_hit(reg_req, MLMC_IDX_BAND_AUX))
        band_aux_reg <= {2'h0, reg_req.wdata[MLMC_POS_AUX_RATE +: 2],
          fix_band(reg_req.wdata[MLMC_POS_BAND +: 4])};
    end
  end

  // register reads, spare and unmapped read as zero
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_reg <= 8'h00;
      reg_ack_reg <= 1'b0;
    end
    else if (ce)
    begin
      reg_ack_reg <= reg_req.rd || reg_req.wr;
      if (reg_req.rd)
      begin
        unique case (reg_req.idx)
          MLMC_IDX_LINE_MAP: reg_rdata_reg <= line_map_reg;
          MLMC_IDX_MULTIDROP: reg_rdata_reg <= multidrop_reg;
          MLMC_IDX_SPECIAL: reg_rdata_reg <= special_reg;
          MLMC_IDX_LOW_POWER: reg_rdata_reg <= low_power_reg;
          MLMC_IDX_BAND_AUX: reg_rdata_reg <= band_aux_reg;
          default: reg_rdata_reg <= MLMC_RST_SPARE;
        endcase
      end
    end
  end

  // reception enable state
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rx_enabled_reg <= 1'b1;
    else if (ce)
    begin
      if (cmd_rx_enable)
        rx_enabled_reg <= 1'b1;
      else if (cmd_rx_disable)
        rx_enabled_reg <= 1'b0;
      else if (rx_start && packet_mode)
        rx_enabled_reg <= !line_map_reg[MLMC_BIT_RX_INIT_OFF];
    end
  end

  // control line forwarding
  mlmc_line_fwd u_dcd_fwd (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .mode(line_map_reg[MLMC_POS_DCD +: 2]),
    .remote(remote_dcd),
    .line_out(dcd_fwd)
  );

  mlmc_line_fwd u_dsr_fwd (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .mode(line_map_reg[MLMC_POS_DTR +: 2]),
    .remote(remote_dtr),
    .line_out(dsr_fwd)
  );

  mlmc_line_fwd u_cts_fwd (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .mode(line_map_reg[MLMC_POS_RTS +: 2]),
    .remote(remote_rts),
    .line_out(cts_fwd)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dcd_out_reg <= 1'b1;
      dsr_out_reg <= 1'b1;
      cts_out_reg <= 1'b1;
    end
    else if (ce)
    begin
      if (direct_mode && special_reg[MLMC_BIT_DCD_SYNC])
        dcd_out_reg <= direct_sync_clk;
      else
        dcd_out_reg <= dcd_fwd;
      dsr_out_reg <= dsr_fwd;
      if (hw_flow)
        cts_out_reg <= host_rx_ready;
      else
        cts_out_reg <= cts_fwd;
    end
  end

  // multi-drop output scheduling
  assign periodic = multidrop_reg[MLMC_BIT_PERIODIC];
  assign coll_avoid = multidrop_reg[MLMC_BIT_COLL_AVOID];
  assign line_free = !coll_avoid || !line_busy;

  always_comb
  begin
    md_state_next = md_state_reg;
    unique case (md_state_reg)
      MLMC_MD_READY:
        if (interval_expire && !line_free)
          md_state_next = MLMC_MD_WAIT;
      MLMC_MD_WAIT:
        if (!line_busy)
          md_state_next = MLMC_MD_RESTART;
      MLMC_MD_RESTART:
        md_state_next = MLMC_MD_READY;
      default:
        md_state_next = MLMC_MD_READY;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      md_state_reg <= MLMC_MD_READY;
    else if (ce)
      md_state_reg <= md_state_next;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      send_grant_reg <= 1'b0;
      send_cr_reg <= 1'b0;
      interval_restart_reg <= 1'b0;
      cr_byte_reg <= 8'h00;
    end
    else if (ce)
    begin
      send_grant_reg <= (md_state_reg == MLMC_MD_READY) && interval_expire
        && line_free && out_pending;
      send_cr_reg <= (md_state_reg == MLMC_MD_READY) && interval_expire
        && line_free && !out_pending && periodic;
      interval_restart_reg <= (md_state_reg == MLMC_MD_WAIT) && !line_busy;
      cr_byte_reg <= MLMC_CR_BYTE;
    end
  end

  // replies to completed commands
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reply_accepted_reg <= 1'b0;
      reply_tx_accepted_reg <= 1'b0;
    end
    else if (ce)
    begin
      reply_accepted_reg <= cmd.done && !cmd.is_tx && (!is_global(cmd.addr)
        || multidrop_reg[MLMC_BIT_GLOBAL_REPLY]);
      reply_tx_accepted_reg <= cmd.done && cmd.is_tx && (!is_global(cmd.addr)
        || multidrop_reg[MLMC_BIT_GLOBAL_REPLY]);
    end
  end

  // direct, low-power, band outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      short_delay_reg <= 1'b0;
      lowpower_en_reg <= 1'b0;
      ctrl_channel_en_reg <= 1'b0;
      band_sel_reg <= MLMC_BAND_DEFAULT;
      aux_clk_reg <= 1'b0;
    end
    else if (ce)
    begin
      short_delay_reg <= direct_mode && special_reg[MLMC_BIT_SHORT_DELAY];
      lowpower_en_reg <= low_power_reg[MLMC_BIT_LP_EN];
      ctrl_channel_en_reg <= low_power_reg[MLMC_BIT_LP_EN]
        && low_power_reg[MLMC_BIT_CTRL_CHAN];
      band_sel_reg <= band_aux_reg[MLMC_POS_BAND +: 4];
      aux_clk_reg <= aux_clk_int;
    end
  end

  mlmc_aux_clk u_aux_clk (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .rate(band_aux_reg[MLMC_POS_AUX_RATE +: 2]),
    .aux_clk(aux_clk_int)
  );

  a_rx_enable_cmd: assert property (@(posedge sys_clk) disable iff (rst)
    ce && cmd_rx_enable |=> rx_enabled_reg)
    else $error("enable command did not enable reception");

  a_rx_start_load: assert property (@(posedge sys_clk) disable iff (rst)
    ce && rx_start && packet_mode && !cmd_rx_enable && !cmd_rx_disable
    |=> rx_enabled_reg == !$past(line_map_reg[MLMC_BIT_RX_INIT_OFF]))
    else $error("initial reception state wrong");

  a_cts_hw_flow: assert property (@(posedge sys_clk) disable iff (rst)
    ce && hw_flow |=> cts_out_reg == $past(host_rx_ready))
    else $error("cts not following flow control");

  a_global_silent: assert property (@(posedge sys_clk) disable iff (rst)
    ce && cmd.done && is_global(cmd.addr) && !multidrop_reg[MLMC_BIT_GLOBAL_REPLY]
    |=> !reply_accepted_reg && !reply_tx_accepted_reg)
    else $error("reply sent to global command");

  a_global_reply: assert property (@(posedge sys_clk) disable iff (rst)
    ce && cmd.done && multidrop_reg[MLMC_BIT_GLOBAL_REPLY]
    |=> reply_accepted_reg || reply_tx_accepted_reg)
    else $error("missing reply");

  a_cr_when_empty: assert property (@(posedge sys_clk) disable iff (rst)
    ce && md_state_reg == MLMC_MD_READY && interval_expire && line_free
    && !out_pending && periodic |=> send_cr_reg && !send_grant_reg)
    else $error("carriage return not sent");

  a_busy_defer: assert property (@(posedge sys_clk) disable iff (rst)
    ce && md_state_reg == MLMC_MD_READY && interval_expire && coll_avoid && line_busy
    |=> !send_grant_reg && !send_cr_reg && md_state_reg == MLMC_MD_WAIT)
    else $error("output on busy line");

  a_band_legal: assert property (@(posedge sys_clk) disable iff (rst)
    band_sel_reg != 4'h0 && band_sel_reg != MLMC_BAND_INVALID
    && band_sel_reg <= MLMC_BAND_LAST)
    else $error("illegal band selected");

  a_lowpower_off: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !low_power_reg[MLMC_BIT_LP_EN] |=> !lowpower_en_reg && !ctrl_channel_en_reg)
    else $error("low-power mode without enable");

endmodule

// ==== mlmc_host_model.sv ====
module mlmc_host_model
  import mlmc_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // requests and flow state towards the device
  output mlmc_regreq_type reg_req,
  output mlmc_cmd_type cmd,
  output logic cmd_rx_enable,
  output logic cmd_rx_disable,
  output logic host_rx_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    reg_req = '0;
    cmd = '0;
    cmd_rx_enable = 1'b0;
    cmd_rx_disable = 1'b0;
    host_rx_ready = 1'b0;
  end

  // one-cycle register request, launched off the falling edge
  task automatic access(input logic wr, input logic [4:0] idx, input logic [7:0] data);
    @(negedge sys_clk);
    reg_req = '{wr: wr, rd: !wr, idx: idx, wdata: data};
    @(negedge sys_clk);
    reg_req = '0;
  endtask

  // finished command with its target address
  task automatic command(input logic is_tx, input logic [7:0] addr);
    @(negedge sys_clk);
    cmd = '{done: 1'b1, is_tx: is_tx, addr: addr};
    @(negedge sys_clk);
    cmd = '0;
  endtask

  // reception enable or disable command
  task automatic rx_cmd(input logic en);
    @(negedge sys_clk);
    cmd_rx_enable = en;
    cmd_rx_disable = !en;
    @(negedge sys_clk);
    cmd_rx_enable = 1'b0;
    cmd_rx_disable = 1'b0;
  endtask

  // local readiness carried on the flow control lines
  task automatic set_ready(input logic v);
    @(negedge sys_clk);
    host_rx_ready = v;
  endtask
endmodule

// ==== mlmc_config_tb.sv ====
`define CHK(g, e) chk(g, e)
module mlmc_config_tb
  import mlmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] RSTV [6] = '{8'h00, 8'h00, 8'hC0, 8'h40, 8'h00, 8'h01};
  localparam logic [7:0] FFV [6] = '{8'hBF, 8'h17, 8'hF0, 8'hC0, 8'h00, 8'h31};
  localparam logic [7:0] GADDR [4] = '{8'hF0, 8'hFE, 8'hEF, 8'hFF};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic packet_mode = 1'b0, direct_mode = 1'b0, hw_flow = 1'b0, rx_start = 1'b0;
  logic direct_sync_clk = 1'b0, interval_expire = 1'b0, line_busy = 1'b0, out_pending = 1'b0;
  mlmc_remote_type remote_dcd = '0, remote_dtr = '0, remote_rts = '0;
  mlmc_regreq_type reg_req;
  mlmc_cmd_type cmd;
  logic cmd_rx_enable, cmd_rx_disable, host_rx_ready;
  logic [7:0] reg_rdata_reg, cr_byte_reg;
  logic [3:0] band_sel_reg;
  logic reg_ack_reg, dcd_out_reg, dsr_out_reg, cts_out_reg, rx_enabled_reg, send_grant_reg;
  logic send_cr_reg, interval_restart_reg, reply_accepted_reg, reply_tx_accepted_reg;
  logic short_delay_reg, lowpower_en_reg, ctrl_channel_en_reg, aux_clk_reg;
  int errors = 0;
  int checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  mlmc_host_model mlmc_host_model_i (.sys_clk(sys_clk), .reg_req(reg_req), .cmd(cmd),
    .cmd_rx_enable(cmd_rx_enable), .cmd_rx_disable(cmd_rx_disable),
    .host_rx_ready(host_rx_ready));

  mlmc_config mlmc_config_i (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
    .reg_rdata_reg(reg_rdata_reg), .reg_ack_reg(reg_ack_reg), .packet_mode(packet_mode),
    .direct_mode(direct_mode), .hw_flow(hw_flow), .rx_start(rx_start),
    .cmd_rx_enable(cmd_rx_enable), .cmd_rx_disable(cmd_rx_disable), .remote_dcd(remote_dcd),
    .remote_dtr(remote_dtr), .remote_rts(remote_rts), .host_rx_ready(host_rx_ready),
    .direct_sync_clk(direct_sync_clk), .interval_expire(interval_expire),
    .line_busy(line_busy), .out_pending(out_pending), .cmd(cmd), .dcd_out_reg(dcd_out_reg),
    .dsr_out_reg(dsr_out_reg), .cts_out_reg(cts_out_reg), .rx_enabled_reg(rx_enabled_reg),
    .send_grant_reg(send_grant_reg), .send_cr_reg(send_cr_reg),
    .interval_restart_reg(interval_restart_reg), .cr_byte_reg(cr_byte_reg),
    .reply_accepted_reg(reply_accepted_reg), .reply_tx_accepted_reg(reply_tx_accepted_reg),
    .short_delay_reg(short_delay_reg), .lowpower_en_reg(lowpower_en_reg),
    .ctrl_channel_en_reg(ctrl_channel_en_reg), .aux_clk_reg(aux_clk_reg),
    .band_sel_reg(band_sel_reg));

  task automatic summarize();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    mlmc_host_model_i.access(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
    mlmc_host_model_i.access(1'b0, idx, 8'h00);
    `CHK(reg_ack_reg, 1'b1);
    `CHK(reg_rdata_reg, exp);
  endtask

  task automatic pulse_expire();
    step(1);
    interval_expire = 1'b1;
    step(1);
    interval_expire = 1'b0;
  endtask

  task automatic t_regs();
    logic [3:0] e;
    for (int i = 0; i < 6; i++)
      rd_chk(5'h16 + 5'(i), RSTV[i]);
    rd_chk(5'h05, 8'h00);
    `CHK({dcd_out_reg, dsr_out_reg, cts_out_reg, rx_enabled_reg}, 4'hF);
    for (int i = 0; i < 6; i++)
    begin
      wr(5'h16 + 5'(i), 8'hFF);
      rd_chk(5'h16 + 5'(i), FFV[i]);
    end
    wr(5'h16, 8'h55);
    rd_chk(5'h16, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      e = (c == 0 || c == 2 || c > 6) ? 4'h1 : 4'(c);
      wr(5'h1B, 8'(c));
      rd_chk(5'h1B, {4'h0, e});
      `CHK(band_sel_reg, e);
    end
  endtask

  task automatic t_rx();
    packet_mode = 1'b1;
    wr(5'h16, 8'h80);
    rx_start = 1'b1;
    step(1);
    rx_start = 1'b0;
    step(1);
    `CHK(rx_enabled_reg, 1'b0);
    mlmc_host_model_i.rx_cmd(1'b1);
    step(1);
    `CHK(rx_enabled_reg, 1'b1);
    mlmc_host_model_i.rx_cmd(1'b0);
    wr(5'h16, 8'h00);
    rx_start = 1'b1;
    step(1);
    rx_start = 1'b0;
    step(1);
    `CHK(rx_enabled_reg, 1'b1);
  endtask

  task automatic t_lines();
    for (int c = 2; c < 4; c++)
    begin
      wr(5'h16, 8'(c * 21));
      step(3);
      `CHK({dcd_out_reg, dsr_out_reg, cts_out_reg}, {3{c[0]}});
      remote_dcd = '{level: !c[0], valid: 1'b1};
      remote_dtr = '{level: !c[0], valid: 1'b1};
      remote_rts = '{level: !c[0], valid: 1'b1};
      step(1);
      remote_dcd.valid = 1'b0;
      remote_dtr.valid = 1'b0;
      remote_rts.valid = 1'b0;
      step(3);
      `CHK({dcd_out_reg, dsr_out_reg, cts_out_reg}, {3{!c[0]}});
    end
    wr(5'h16, 8'h00);
    step(3);
    `CHK({dcd_out_reg, dsr_out_reg, cts_out_reg}, 3'h7);
    wr(5'h16, 8'h03);
    hw_flow = 1'b1;
    step(3);
    `CHK(cts_out_reg, 1'b0);
    mlmc_host_model_i.set_ready(1'b1);
    step(2);
    `CHK(cts_out_reg, 1'b1);
    hw_flow = 1'b0;
  endtask

  task automatic t_multidrop();
    wr(5'h17, 8'h04); // periodic output on this modem only
    pulse_expire();
    `CHK({send_cr_reg, send_grant_reg}, 2'h2);
    `CHK(cr_byte_reg, 8'h0D);
    out_pending = 1'b1;
    pulse_expire();
    `CHK({send_cr_reg, send_grant_reg}, 2'h1);
    wr(5'h17, 8'h02);
    line_busy = 1'b1;
    pulse_expire();
    `CHK(send_grant_reg, 1'b0);
    step(2);
    line_busy = 1'b0;
    step(1);
    `CHK(interval_restart_reg, 1'b1);
    step(2);
    pulse_expire();
    `CHK(send_grant_reg, 1'b1);
    out_pending = 1'b0;
    wr(5'h17, 8'h00);
    pulse_expire();
    `CHK(send_cr_reg, 1'b0);
  endtask

  task automatic t_replies();
    logic ok;
    for (int i = 0; i < 4; i++)
    begin
      ok = !(GADDR[i] >= 8'hF0 && GADDR[i] <= 8'hFE);
      mlmc_host_model_i.command(i[0], GADDR[i]);
      `CHK({reply_accepted_reg, reply_tx_accepted_reg}, {ok & !i[0], ok & i[0]});
    end
    wr(5'h17, 8'h01);
    mlmc_host_model_i.command(1'b1, 8'hF0);
    `CHK({reply_accepted_reg, reply_tx_accepted_reg}, 2'h1);
  endtask

  task automatic t_modes();
    logic [7:0] lp [3];
    lp = '{8'h80, 8'hC0, 8'h40};
    direct_mode = 1'b1;
    wr(5'h18, 8'h20);
    step(2);
    `CHK(short_delay_reg, 1'b1);
    wr(5'h18, 8'h10);
    step(3);
    `CHK({short_delay_reg, dcd_out_reg}, 2'h0);
    direct_sync_clk = 1'b1;
    step(2);
    `CHK(dcd_out_reg, 1'b1);
    direct_sync_clk = 1'b0;
    direct_mode = 1'b0;
    step(3);
    `CHK(dcd_out_reg, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      wr(5'h19, lp[i]);
      step(1);
      `CHK({lowpower_en_reg, ctrl_channel_en_reg}, {lp[i][7], &lp[i][7:6]});
    end
  endtask

  task automatic t_ce();
    ce = 1'b0;
    wr(5'h19, 8'hC0);
    ce = 1'b1;
    rd_chk(5'h19, 8'h40);
  endtask

  task automatic wait_rise(output int n);
    n = 0;
    while (!(aux_clk_reg === 1'b1))
    begin
      step(1);
      n++;
      if (n > 3000)
      begin
        errors++;
        summarize();
      end
    end
    while (aux_clk_reg === 1'b1 && n <= 3000)
    begin
      step(1);
      n++;
    end
  endtask

  task automatic t_aux();
    int per [3];
    int n;
    per = '{MLMC_AUX_SLOW_CYC, MLMC_AUX_MID_CYC, MLMC_AUX_FAST_CYC};
    for (int c = 1; c < 4; c++)
    begin
      wr(5'h1B, 8'h01 | 8'(c << 4));
      wait_rise(n);
      wait_rise(n);
      `CHK(16'(n), 16'(per[c - 1]));
    end
    wr(5'h1B, 8'h01);
    step(3);
    n = 0;
    repeat (100)
    begin
      step(1);
      n += int'(aux_clk_reg !== 1'b0);
    end
    `CHK(16'(n), 16'h0000);
  endtask

  initial
  begin
    #400000;
    errors++;
    summarize();
  end

  initial
  begin
    step(12);
    rst = 1'b0;
    step(1);
    t_regs();
    t_rx();
    t_lines();
    t_multidrop();
    t_replies();
    t_modes();
    t_aux();
    t_ce();
    summarize();
  end
endmodule
